// file: rtl/otfs_defines.vh
// Purpose: Shared constants for the output terminal function selector
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Selection codes, register offsets, reset values and widths
`ifndef OTFS_DEFINES_VH
`define OTFS_DEFINES_VH

// Selection codes held in each terminal's selection register
`define OTFS_CODE_NONE        16'h0000
`define OTFS_CODE_RUN         16'h0001
`define OTFS_CODE_SPEED       16'h0002
`define OTFS_CODE_FREQ_ONE    16'h0003
`define OTFS_CODE_FREQ_TWO    16'h0004
`define OTFS_CODE_ZERO_RUN    16'h0005
`define OTFS_CODE_ZERO_STOP   16'h0006
`define OTFS_CODE_TORQUE_ONE  16'h0007
`define OTFS_CODE_TORQUE_TWO  16'h0008
`define OTFS_CODE_READY       16'h0009
`define OTFS_CODE_LOW_VOLT    16'h000A
`define OTFS_CODE_FAULT       16'h000B
`define OTFS_CODE_OVERHEAT    16'h000D
`define OTFS_CODE_BRAKE       16'h000E
`define OTFS_CODE_FEEDBACK    16'h000F
`define OTFS_CODE_SLIP        16'h0010
`define OTFS_CODE_SPEED_STOP  16'h0028
`define OTFS_CODE_MOTOR_SPEED 16'h002B
`define OTFS_CODE_LOW_CURRENT 16'h002C
`define OTFS_CODE_SERIAL      16'h0033
`define OTFS_CODE_CARD        16'h0034
`define OTFS_CODE_FIRE        16'h0035
`define OTFS_CODE_SAFE_A      16'h0042
`define OTFS_CODE_ANALOG      16'h0043
`define OTFS_CODE_SAFE_B      16'h0044
`define OTFS_CODE_FWD_RUN     16'h004B
`define OTFS_CODE_REV_RUN     16'h004C

// Register byte offsets
`define OTFS_SEL_BASE         8'h00
`define OTFS_SEL_LAST         8'h3C
`define OTFS_SERIAL_OUT       8'h40
`define OTFS_CARD_OUT         8'h44
`define OTFS_TERM_STATE       8'h48

// Reset values
`define OTFS_SEL_RESET        16'h0000
`define OTFS_DIRECT_RESET     16'h0000

// Widths
`define OTFS_CODE_W           16
`define OTFS_MAX_TERM         16

`endif

// file: rtl/otfs_selector.v
// Purpose: Per-terminal selection of a drive condition onto digital outputs
// Assumes: Condition inputs come from logic on the same clock; AHB-Lite slave
// Notes:   Zero wait states; outputs and bus answers are registered
// Register map, one aligned word each, upper bits read zero:
//   0x00 + 4n  selection code of terminal n (16 bits)
//   0x40       direct values for code 51, bit n per terminal
//   0x44       direct values for code 52, bit n per terminal
//   0x48       terminal state, read only
// Unmapped offsets read zero and drop writes; the slave never stalls.
// A read in the cycle after a write to the same offset sees the new value.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "otfs_defines.vh"

module otfs_selector #(
    parameter NUM_TERM = 4                  // Number of output terminals
) (
    input  wire                 clock,
    input  wire                 rst,
    // AHB-Lite slave
    input  wire                 hsel,
    input  wire [31:0]          haddr,
    input  wire [1:0]           htrans,
    input  wire                 hwrite,
    input  wire [2:0]           hsize,
    input  wire [31:0]          hwdata,
    input  wire                 hready,
    output reg                  hreadyout,
    output reg  [31:0]          hrdata,
    output reg                  hresp,
    // Drive conditions, all active high
    input  wire                 driveRunning,
    input  wire                 speedReached,
    input  wire                 freqReachedOne,
    input  wire                 freqReachedTwo,
    input  wire                 freqCmdZero,
    input  wire                 overTorqueOne,
    input  wire                 overTorqueTwo,
    input  wire                 drivePowered,
    input  wire                 errorPresent,
    input  wire                 lowBusVoltage,
    input  wire                 faultActive,
    input  wire                 faultIsLowVoltage,
    input  wire                 overheatWarn,
    input  wire                 softBrakeActive,
    input  wire                 feedbackError,
    input  wire                 slipError,
    input  wire                 motorSpeedDetect,
    input  wire                 lowCurrentDetect,
    input  wire                 fireMode,
    input  wire                 safetyOutput,
    input  wire                 analogLevelReached,
    input  wire                 runForward,
    input  wire                 runReverse,
    // Terminal drive
    output reg  [NUM_TERM-1:0]  termOut
);

    // Condition vector indices
    localparam C_RUN   = 0;
    localparam C_SPD   = 1;
    localparam C_F1    = 2;
    localparam C_F2    = 3;
    localparam C_ZRUN  = 4;
    localparam C_ZSTP  = 5;
    localparam C_T1    = 6;
    localparam C_T2    = 7;
    localparam C_RDY   = 8;
    localparam C_LV    = 9;
    localparam C_FLT   = 10;
    localparam C_HOT   = 11;
    localparam C_BRK   = 12;
    localparam C_FB    = 13;
    localparam C_SLIP  = 14;
    localparam C_SSTP  = 15;
    localparam C_MSPD  = 16;
    localparam C_LCUR  = 17;
    localparam C_FIRE  = 18;
    localparam C_SA    = 19;
    localparam C_AN    = 20;
    localparam C_SB    = 21;
    localparam C_FWD   = 22;
    localparam C_REV   = 23;
    localparam C_NUM   = 24;

    // Reset value of the direct-drive registers, cut to the terminal count
    localparam [15:0]        DIRECT_RST = `OTFS_DIRECT_RESET;

    // Configuration and bus state
    reg  [`OTFS_CODE_W-1:0]  sel_q [0:NUM_TERM-1];  // Per-terminal selection codes
    reg  [NUM_TERM-1:0]      serialOut_q;           // Values written over serial link
    reg  [NUM_TERM-1:0]      cardOut_q;             // Values written by the comm card
    reg                      wrPend_q;              // Write data phase pending
    reg  [7:0]               wrAddr_q;              // Latched write offset
    reg  [31:0]              rdData;                // Read word for the next data phase
    wire                     addrPhase;             // Valid transfer taken this edge
    wire [C_NUM-1:0]         cond;                  // Derived conditions
    wire [NUM_TERM-1:0]      term_d;                // Next terminal states
    integer                  k;                     // Loop index of the write process
    integer                  j;                     // Loop index of the read decode

    assign addrPhase = hsel & htrans[1] & hready;

    // Derived conditions from raw drive status
    // Status inputs come from logic on this clock, so no synchroniser sits here
    // Running, speed and frequency thresholds
    assign cond[C_RUN]  = driveRunning;
    assign cond[C_SPD]  = speedReached;
    assign cond[C_F1]   = freqReachedOne;
    assign cond[C_F2]   = freqReachedTwo;

    // Zero frequency command, with and without the stopped state
    assign cond[C_ZRUN] = freqCmdZero & driveRunning;
    assign cond[C_ZSTP] = freqCmdZero | ~driveRunning;

    // Torque, readiness, supply and fault
    assign cond[C_T1]   = overTorqueOne;
    assign cond[C_T2]   = overTorqueTwo;
    assign cond[C_RDY]  = drivePowered & ~errorPresent;
    assign cond[C_LV]   = lowBusVoltage;
    assign cond[C_FLT]  = faultActive & ~faultIsLowVoltage;

    // Warnings and detected errors
    assign cond[C_HOT]  = overheatWarn;
    assign cond[C_BRK]  = softBrakeActive;
    assign cond[C_FB]   = feedbackError;
    assign cond[C_SLIP] = slipError;

    // Speed reached or stopped, speed and current detection
    assign cond[C_SSTP] = speedReached | ~driveRunning;
    assign cond[C_MSPD] = motorSpeedDetect;
    assign cond[C_LCUR] = lowCurrentDetect;

    // Fire mode, safety output in both senses, analog level
    assign cond[C_FIRE] = fireMode;
    assign cond[C_SA]   = safetyOutput;
    assign cond[C_AN]   = analogLevelReached;
    assign cond[C_SB]   = ~safetyOutput;

    // Direction counts only while running, so a stopped drive shows neither
    assign cond[C_FWD]  = driveRunning & runForward;
    assign cond[C_REV]  = driveRunning & runReverse;

    // Picks one condition for a selection code
    // Undefined codes fall to the default branch and stay inactive
    function pick_cond;
        input [`OTFS_CODE_W-1:0] code;
        input [C_NUM-1:0]        c;
        input                    serialBit;
        input                    cardBit;
        begin
            case (code)
                // No function
                `OTFS_CODE_NONE:        pick_cond = 1'b0;

                // Running, speed and frequency thresholds
                `OTFS_CODE_RUN:         pick_cond = c[C_RUN];
                `OTFS_CODE_SPEED:       pick_cond = c[C_SPD];
                `OTFS_CODE_FREQ_ONE:    pick_cond = c[C_F1];
                `OTFS_CODE_FREQ_TWO:    pick_cond = c[C_F2];

                // Zero frequency command
                `OTFS_CODE_ZERO_RUN:    pick_cond = c[C_ZRUN];
                `OTFS_CODE_ZERO_STOP:   pick_cond = c[C_ZSTP];

                // Torque, readiness, supply and fault
                `OTFS_CODE_TORQUE_ONE:  pick_cond = c[C_T1];
                `OTFS_CODE_TORQUE_TWO:  pick_cond = c[C_T2];
                `OTFS_CODE_READY:       pick_cond = c[C_RDY];
                `OTFS_CODE_LOW_VOLT:    pick_cond = c[C_LV];
                `OTFS_CODE_FAULT:       pick_cond = c[C_FLT];

                // Warnings and detected errors
                `OTFS_CODE_OVERHEAT:    pick_cond = c[C_HOT];
                `OTFS_CODE_BRAKE:       pick_cond = c[C_BRK];
                `OTFS_CODE_FEEDBACK:    pick_cond = c[C_FB];
                `OTFS_CODE_SLIP:        pick_cond = c[C_SLIP];

                // Speed reached or stopped, speed and current detection
                `OTFS_CODE_SPEED_STOP:  pick_cond = c[C_SSTP];
                `OTFS_CODE_MOTOR_SPEED: pick_cond = c[C_MSPD];
                `OTFS_CODE_LOW_CURRENT: pick_cond = c[C_LCUR];

                // Values written by software over the two links
                `OTFS_CODE_SERIAL:      pick_cond = serialBit;
                `OTFS_CODE_CARD:        pick_cond = cardBit;

                // Fire mode, safety output and analog level
                `OTFS_CODE_FIRE:        pick_cond = c[C_FIRE];
                `OTFS_CODE_SAFE_A:      pick_cond = c[C_SA];
                `OTFS_CODE_ANALOG:      pick_cond = c[C_AN];
                `OTFS_CODE_SAFE_B:      pick_cond = c[C_SB];

                // Direction while running
                `OTFS_CODE_FWD_RUN:     pick_cond = c[C_FWD];
                `OTFS_CODE_REV_RUN:     pick_cond = c[C_REV];

                // Every other code, undefined ones included
                default:                pick_cond = 1'b0;
            endcase
        end
    endfunction

    // Selection register index for an offset, or NUM_TERM when none
    // Only aligned words inside the selection window map to a terminal
    function integer sel_index;
        input [7:0] off;
        begin
            if ((off[1:0] == 2'b00) && (off <= `OTFS_SEL_LAST)
                && ({2'b00, off[7:2]} < NUM_TERM))
                sel_index = {26'h0000000, off[7:2]};
            else
                sel_index = NUM_TERM;
        end
    endfunction

    // One independent selector per terminal
    // Each terminal reads only its own code, so terminals never interfere
    genvar t;
    generate
        for (t = 0; t < NUM_TERM; t = t + 1)
        begin : gTerm
            assign term_d[t] = pick_cond(sel_q[t], cond, serialOut_q[t], cardOut_q[t]);
        end
    endgenerate

    // Terminal output register; a terminal follows its condition one edge late
    always @(posedge clock)
    begin
        if (rst)
            termOut <= {NUM_TERM{1'b0}};            // All terminals inactive in reset
        else
            termOut <= term_d;                      // Registered selector result
    end

    // Address phase capture; writes land one cycle later in the data phase
    always @(posedge clock)
    begin
        if (rst)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end
        else if (hready)
        begin
            // Held while the bus stalls, so a data phase keeps its offset
            wrPend_q <= addrPhase & hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    // Register writes in the data phase
    always @(posedge clock)
    begin
        if (rst)
        begin
            for (k = 0; k < NUM_TERM; k = k + 1)
                sel_q[k] <= `OTFS_SEL_RESET;
            serialOut_q <= DIRECT_RST[NUM_TERM-1:0];
            cardOut_q   <= DIRECT_RST[NUM_TERM-1:0];
        end
        else if (wrPend_q)
        begin
            // Writes to unmapped offsets are dropped
            for (k = 0; k < NUM_TERM; k = k + 1)
                if (sel_index(wrAddr_q) == k)
                    sel_q[k] <= hwdata[`OTFS_CODE_W-1:0];
            if (wrAddr_q == `OTFS_SERIAL_OUT)
                serialOut_q <= hwdata[NUM_TERM-1:0];
            if (wrAddr_q == `OTFS_CARD_OUT)
                cardOut_q <= hwdata[NUM_TERM-1:0];
        end
    end

    // Read data, prepared in the address phase so it stands in the data phase
    always @*
    begin
        rdData = 32'h0000_0000;
        for (j = 0; j < NUM_TERM; j = j + 1)
            if (sel_index(haddr[7:0]) == j)
                rdData = {16'h0000, sel_q[j]};
        if (haddr[7:0] == `OTFS_SERIAL_OUT)
            rdData[NUM_TERM-1:0] = serialOut_q;
        if (haddr[7:0] == `OTFS_CARD_OUT)
            rdData[NUM_TERM-1:0] = cardOut_q;
        if (haddr[7:0] == `OTFS_TERM_STATE)
            rdData[NUM_TERM-1:0] = termOut;
        // A write still in its data phase has not landed yet: show what it
        // leaves behind, cut to the register's width, and nothing for unmapped
        // offsets or the read-only terminal state
        if (wrPend_q && (wrAddr_q == haddr[7:0]))
        begin
            if (sel_index(haddr[7:0]) < NUM_TERM)
                rdData = {16'h0000, hwdata[`OTFS_CODE_W-1:0]};
            else if ((haddr[7:0] == `OTFS_SERIAL_OUT) || (haddr[7:0] == `OTFS_CARD_OUT))
                rdData[NUM_TERM-1:0] = hwdata[NUM_TERM-1:0];
        end
    end

    // Bus answer registers; ready once out of reset, always OKAY
    always @(posedge clock)
    begin
        if (rst)
        begin
            hreadyout <= 1'b0;                      // Not ready while in reset
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;                      // No wait states are inserted
            hresp     <= 1'b0;                      // Every access answers OKAY
            // Read data stands until the next read address phase is taken
            if (addrPhase && !hwrite)
                hrdata <= rdData;
        end
    end

endmodule

`default_nettype wire

// file: sim/otfs_selector_props.sv
// Purpose: Concurrent checks on terminal zero and on the bus answer
// Assumes: Terminal zero code is shadowed from bus writes to its register
// Notes:   Bound into every selector instance below
`timescale 1ns/100ps
`default_nettype none

module otfs_selector_props #(
    parameter NUM_TERM = 4              // Terminal count handed on by the bind
) (
    input wire logic                clock,
    input wire logic                rst,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                driveRunning,
    input wire logic                speedReached,
    input wire logic                freqCmdZero,
    input wire logic                drivePowered,
    input wire logic                errorPresent,
    input wire logic                faultActive,
    input wire logic                faultIsLowVoltage,
    input wire logic                safetyOutput,
    input wire logic [NUM_TERM-1:0] termOut
);
    logic        wrPend_q;              // Write address phase to terminal zero seen
    logic [15:0] codeSel_q;             // Shadow of terminal zero code

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // Shadow register updates at the end of the data phase, as the design's does
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wrPend_q  <= 1'b0;
            codeSel_q <= 16'h0000;
        end
        else
        begin
            wrPend_q <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == 8'h00);
            if (wrPend_q)
                codeSel_q <= hwdata[15:0];
        end
    end

    property p_answer; hsel && htrans[1] && hready |=> hreadyout && !hresp; endproperty
    a_answer: assert property (p_answer) else $error("bus answer not ready or not okay");
    property p_none; codeSel_q == 16'h0000 |=> !termOut[0]; endproperty
    a_none: assert property (p_none) else $error("code zero drove terminal");
    property p_run; codeSel_q == 16'h0001 |=> termOut[0] == $past(driveRunning); endproperty
    a_run: assert property (p_run) else $error("run indication wrong");
    property p_zstop; codeSel_q == 16'h0006 |=> termOut[0] == $past(freqCmdZero || !driveRunning);
    endproperty
    a_zstop: assert property (p_zstop) else $error("zero speed with stop wrong");
    property p_ready; codeSel_q == 16'h0009 |=> termOut[0] == $past(drivePowered && !errorPresent);
    endproperty
    a_ready: assert property (p_ready) else $error("ready indication wrong");
    property p_fault;
        codeSel_q == 16'h000B |=> termOut[0] == $past(faultActive && !faultIsLowVoltage);
    endproperty
    a_fault: assert property (p_fault) else $error("fault indication wrong");
    property p_spst; codeSel_q == 16'h0028 |=> termOut[0] == $past(speedReached || !driveRunning);
    endproperty
    a_spst: assert property (p_spst) else $error("speed or stop wrong");
    property p_safeb; codeSel_q == 16'h0044 |=> termOut[0] != $past(safetyOutput); endproperty
    a_safeb: assert property (p_safeb) else $error("safety sense B wrong");
    property p_undef; codeSel_q == 16'h000C |=> !termOut[0]; endproperty
    a_undef: assert property (p_undef) else $error("undefined code drove terminal");
endmodule

bind otfs_selector otfs_selector_props #(.NUM_TERM(NUM_TERM)) chk (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .driveRunning(driveRunning), .speedReached(speedReached), .freqCmdZero(freqCmdZero),
    .drivePowered(drivePowered), .errorPresent(errorPresent), .faultActive(faultActive),
    .faultIsLowVoltage(faultIsLowVoltage), .safetyOutput(safetyOutput), .termOut(termOut));
`default_nettype wire

// file: sim/otfs_relay_model.sv
// Purpose: Relays wired to the output terminals
// Assumes: Coil pulls in one clock after the terminal goes active
// Notes:   Relays drop out during reset
`timescale 1ns/100ps
`default_nettype none

module otfs_relay_model #(
    parameter N = 4                     // Relays, one per terminal
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [N-1:0] termIn,
    output var  logic [N-1:0] relayOn
);
    // Contacts follow the coil drive one cycle late
    always_ff @(posedge clock)
    begin
        relayOn <= rst ? '0 : termIn;
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: Register and terminal checks of the selector
// Assumes: Four terminals, zero wait state bus slave
// Notes:   Every code from 0 to 80 plus all ones is swept on terminal zero
`timescale 1ns/100ps
`default_nettype none
`include "otfs_defines.vh"

module tb_top;
    logic        clock, rst, hsel, hwrite;      // Clock, reset, bus controls
    logic [31:0] haddr, hwdata, rdat;           // Bus address, write data, read result
    logic [1:0]  htrans;                        // Transfer type
    logic [2:0]  hsize = 3'h2;                  // Always whole words
    logic [22:0] c, v;                          // Condition inputs and next pattern
    logic [15:0] k;                             // Code under test
    wire logic   hreadyout, hresp;              // Slave answer
    wire logic [31:0] hrdata;                   // Read data
    wire logic [3:0]  termOut, relayOn;         // Terminals and relays
    integer      fails, checked, i, p;          // Counters and loop indices

    otfs_selector #(.NUM_TERM(4)) uut (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .driveRunning(c[0]), .speedReached(c[1]), .freqReachedOne(c[2]),
        .freqReachedTwo(c[3]), .freqCmdZero(c[4]), .overTorqueOne(c[5]),
        .overTorqueTwo(c[6]), .drivePowered(c[7]), .errorPresent(c[8]),
        .lowBusVoltage(c[9]), .faultActive(c[10]), .faultIsLowVoltage(c[11]),
        .overheatWarn(c[12]), .softBrakeActive(c[13]), .feedbackError(c[14]),
        .slipError(c[15]), .motorSpeedDetect(c[16]), .lowCurrentDetect(c[17]),
        .fireMode(c[18]), .safetyOutput(c[19]), .analogLevelReached(c[20]),
        .runForward(c[21]), .runReverse(c[22]), .termOut(termOut));

    otfs_relay_model #(.N(4)) relays (.clock(clock), .rst(rst), .termIn(termOut),
        .relayOn(relayOn));

    // Expected terminal state; serial value bit is 1, card value bit is 0
    function automatic logic expOut(input logic [15:0] kk, input logic [22:0] w);
        case (kk)
            `OTFS_CODE_RUN:         expOut = w[0];
            `OTFS_CODE_SPEED:       expOut = w[1];
            `OTFS_CODE_FREQ_ONE:    expOut = w[2];
            `OTFS_CODE_FREQ_TWO:    expOut = w[3];
            `OTFS_CODE_ZERO_RUN:    expOut = w[4] & w[0];
            `OTFS_CODE_ZERO_STOP:   expOut = w[4] | ~w[0];
            `OTFS_CODE_TORQUE_ONE:  expOut = w[5];
            `OTFS_CODE_TORQUE_TWO:  expOut = w[6];
            `OTFS_CODE_READY:       expOut = w[7] & ~w[8];
            `OTFS_CODE_LOW_VOLT:    expOut = w[9];
            `OTFS_CODE_FAULT:       expOut = w[10] & ~w[11];
            `OTFS_CODE_OVERHEAT:    expOut = w[12];
            `OTFS_CODE_BRAKE:       expOut = w[13];
            `OTFS_CODE_FEEDBACK:    expOut = w[14];
            `OTFS_CODE_SLIP:        expOut = w[15];
            `OTFS_CODE_SPEED_STOP:  expOut = w[1] | ~w[0];
            `OTFS_CODE_MOTOR_SPEED: expOut = w[16];
            `OTFS_CODE_LOW_CURRENT: expOut = w[17];
            `OTFS_CODE_SERIAL:      expOut = 1'b1;
            `OTFS_CODE_CARD:        expOut = 1'b0;
            `OTFS_CODE_FIRE:        expOut = w[18];
            `OTFS_CODE_SAFE_A:      expOut = w[19];
            `OTFS_CODE_ANALOG:      expOut = w[20];
            `OTFS_CODE_SAFE_B:      expOut = ~w[19];
            `OTFS_CODE_FWD_RUN:     expOut = w[0] & w[21];
            `OTFS_CODE_REV_RUN:     expOut = w[0] & w[22];
            default:                expOut = 1'b0;
        endcase
    endfunction

    // One single transfer: address phase, then data phase, each held until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Watchdog sized well above the full sweep
    initial
    begin
        repeat (40000) @(posedge clock);
        $display("BAD %0t watchdog expired before the tests ended", $time);
        fails++;
        final_report();
    end

    initial
    begin
        {rst, hsel, hwrite, haddr, hwdata, htrans, c, fails, checked} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset values of selections, direct values and terminal state
        for (i = 0; i < 7; i++)
        begin
            bus(1'b0, (i < 4) ? 8'(4 * i) : 8'(8'h40 + 4 * (i - 4)), 32'h0, rdat);
            chk(rdat, 32'h0);
        end
        bus(1'b1, 8'h80, 32'hFFFFFFFF, rdat);
        bus(1'b0, 8'h80, 32'h0, rdat);
        chk(rdat, 32'h0);
        bus(1'b1, `OTFS_TERM_STATE, 32'hFFFFFFFF, rdat);
        bus(1'b0, `OTFS_TERM_STATE, 32'h0, rdat);
        chk(rdat, 32'h0);
        bus(1'b1, `OTFS_SEL_BASE, 32'hFFFFFFFF, rdat);
        bus(1'b0, `OTFS_SEL_BASE, 32'h0, rdat);
        chk(rdat, 32'h0000FFFF);
        bus(1'b1, `OTFS_SERIAL_OUT, 32'h1, rdat);
        bus(1'b1, `OTFS_CARD_OUT, 32'hE, rdat);
        // Sweep codes on terminal zero with walking ones and walking zeros
        for (i = 0; i < 82; i++)
        begin
            k = (i == 81) ? 16'hFFFF : 16'(i);
            bus(1'b1, `OTFS_SEL_BASE, {16'h0000, k}, rdat);
            for (p = 0; p < 48; p++)
            begin
                v = (p < 23) ? 23'h1 << p : (p < 46) ? ~(23'h1 << (p - 23)) : {23{p == 47}};
                @(posedge clock);
                c <= v;
                @(posedge clock);
                @(negedge clock);
                chk({31'h0, termOut[0]}, {31'h0, expOut(k, v)});
                chk({29'h0, termOut[3:1]}, 32'h0);
            end
        end
        // Three terminals showing different conditions at once
        bus(1'b1, `OTFS_SEL_BASE, 32'h0, rdat);
        bus(1'b1, 8'h04, {16'h0000, `OTFS_CODE_RUN}, rdat);
        bus(1'b1, 8'h08, {16'h0000, `OTFS_CODE_SPEED}, rdat);
        bus(1'b1, 8'h0C, {16'h0000, `OTFS_CODE_SAFE_B}, rdat);
        @(posedge clock);
        c <= 23'h000001;
        @(posedge clock);
        @(negedge clock);
        chk({28'h0, termOut}, 32'hA);
        @(negedge clock);
        chk({28'h0, relayOn}, 32'hA);
        bus(1'b0, `OTFS_TERM_STATE, 32'h0, rdat);
        chk(rdat, 32'hA);
        final_report();
    end
endmodule
`default_nettype wire
